// File: rtl/pkt_fifo_device.sv
// packet buffer end: link slave, 64-byte buffer, serialiser and pattern recogniser
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pkt_fifo_device #(
    parameter int BIT_DIV = 4000
) (
    input wire logic clock,
    input wire logic nrst,
    pkt_link_if.device lnk,
    input wire logic rxBit,
    input wire logic rxStrobe,
    output logic txData,
    output logic frameSent,
    output logic matchFlag,
    output logic [1:0] chipMode
);
    import pkt_fifo_pkg::*;

    typedef struct packed {
        logic [2:0] nssS;
        logic [2:0] sckS;
        logic [2:0] mosiS;
        logic [4:0] bitCnt;
        logic [7:0] cmd;
        logic [7:0] inSh;
        logic [7:0] outSh;
        logic [DEPTH-1:0][7:0] mem;
        logic [5:0] rdPtr;
        logic [5:0] wrPtr;
        logic [6:0] count;
        logic vacant;
        logic brim;
        logic level;
        logic levelHold;
        logic overflow;
        logic sent;
        logic match;
        logic settled;
        logic [1:0] mode;
        logic [5:0] thresh;
        logic [7:0] patCfg;
        logic [7:0][7:0] pat;
        ser_t ser;
        logic [7:0] txSh;
        logic [2:0] txBit;
        logic [2:0] syncIdx;
        logic txData;
        logic [15:0] divCnt;
        logic [63:0] win;
        logic [7:0] rxSh;
        logic [2:0] rxCnt;
        logic rxLock;
    } dev_t;

    dev_t s_r, s_nxt;
    logic sckRise, sckFall, nssFall, selected, bitTick, hit;
    logic [63:0] patMask, winN;
    logic [6:0] patShift;
    logic [7:0] wd;

    ////////////////////////////////////////////////////////////////////////////
    // edges of the synchronised link pins; stage 0 is read by stage 1 only
    assign sckRise = s_r.sckS[1] & ~s_r.sckS[2];
    assign sckFall = ~s_r.sckS[1] & s_r.sckS[2];
    assign nssFall = ~s_r.nssS[1] & s_r.nssS[2];
    assign selected = ~s_r.nssS[1];
    assign wd = {s_r.inSh[6:0], s_r.mosiS[1]};
    assign bitTick = (s_r.divCnt == 16'(BIT_DIV - 1));

    // pattern window: newest bit at bit 0, first pattern byte highest
    assign winN = {s_r.win[62:0], rxBit};
    assign patShift = 7'h38 - 7'({s_r.patCfg[2:0], 3'h0});
    assign patMask = ~64'h0 >> patShift;
    assign hit = ((winN ^ (s_r.pat >> patShift)) & patMask) == 64'h0;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic push;
        logic pop;
        logic flush;
        logic matchSet;
        logic doPush;
        logic doPop;
        logic [7:0] pushByte;
        logic [7:0] rdVal;
        logic [1:0] newMode;
        logic [2:0] pIdx;
        logic [6:0] cnt;
        push = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        matchSet = 1'b0;
        pushByte = 8'h00;
        newMode = s_r.mode;
        pIdx = 3'(s_r.cmd[6:0] - ADDR_PATBYTE0);
        s_nxt = s_r;
        s_nxt.nssS = {s_r.nssS[1:0], lnk.nssN};
        s_nxt.sckS = {s_r.sckS[1:0], lnk.sck};
        s_nxt.mosiS = {s_r.mosiS[1:0], lnk.mosi};
        s_nxt.divCnt = bitTick ? 16'h0 : s_r.divCnt + 16'h1;

        // read value for the addressed register
        case (s_r.cmd[6:0])
            ADDR_DATA: rdVal = s_r.mem[s_r.rdPtr];
            ADDR_MODE: rdVal = {6'h0, s_r.mode};
            ADDR_FLAGS: rdVal = {1'b0, s_r.settled, s_r.match, s_r.sent, s_r.overflow,
                s_r.level, s_r.brim, s_r.vacant};
            ADDR_THRESH: rdVal = {2'h0, s_r.thresh};
            ADDR_PATCFG: rdVal = s_r.patCfg;
            default: rdVal = (s_r.cmd[6:0] - ADDR_PATBYTE0 < PAT_BYTES) ? s_r.pat[3'h7 - pIdx]
                : 8'h00;
        endcase

        // link slave: command byte, then data byte in or out
        if (!selected) begin
            s_nxt.bitCnt = 5'h0;
        end else if (sckRise) begin
            s_nxt.inSh = wd;
            s_nxt.bitCnt = s_r.bitCnt + 5'h1;
            if (s_r.bitCnt == CMD_LAST_BIT) begin
                s_nxt.cmd = wd;
            end
            if (s_r.bitCnt == FRAME_LAST_BIT && s_r.cmd[7]) begin
                case (s_r.cmd[6:0])
                    ADDR_DATA: begin
                        push = (s_r.mode != MODE_RX);
                        pushByte = wd;
                    end
                    ADDR_MODE: newMode = wd[1:0];
                    ADDR_FLAGS: begin
                        if (wd[FLG_OVERFLOW]) begin
                            s_nxt.overflow = 1'b0;
                            flush = 1'b1;
                        end
                    end
                    ADDR_THRESH: s_nxt.thresh = wd[5:0];
                    ADDR_PATCFG: s_nxt.patCfg = wd;
                    default: begin
                        if (s_r.cmd[6:0] - ADDR_PATBYTE0 < PAT_BYTES) begin
                            s_nxt.pat[3'h7 - pIdx] = wd;
                        end
                    end
                endcase
            end
        end
        if (selected && sckFall) begin
            if (s_r.bitCnt == FRAME_BITS - 5'h8 && !s_r.cmd[7]) begin
                s_nxt.outSh = rdVal;
                // a transmit in progress owns the read side of the buffer
                pop = (s_r.cmd[6:0] == ADDR_DATA) && (s_r.mode != MODE_TX);
            end else begin
                s_nxt.outSh = {s_r.outSh[6:0], 1'b0};
            end
        end

        // mode change: flush or keep, restart serialiser and recogniser
        if (newMode != s_r.mode) begin
            s_nxt.mode = newMode;
            flush = (newMode == MODE_RX && !s_r.mode[1]) || (s_r.mode == MODE_RX
                && newMode == MODE_TX) || (s_r.mode == MODE_TX);
            s_nxt.settled = !(s_r.mode == MODE_TX && newMode == MODE_SLEEP);
            s_nxt.ser = SER_IDLE;
            s_nxt.rxLock = 1'b0;
            s_nxt.rxCnt = 3'h0;
            if (s_r.mode == MODE_RX) begin
                s_nxt.match = 1'b0;
            end
            if (newMode == MODE_TX) begin
                s_nxt.sent = 1'b0;
                s_nxt.txBit = 3'h0;
                s_nxt.syncIdx = 3'h0;
                if (s_r.patCfg[PAT_EN_BIT]) begin
                    s_nxt.ser = SER_SYNC;
                    s_nxt.txSh = s_r.pat[7];
                end else if (s_r.count != 7'h0) begin
                    s_nxt.ser = SER_DATA;
                    s_nxt.txSh = s_r.mem[s_r.rdPtr];
                    pop = 1'b1;
                end else begin
                    s_nxt.ser = SER_TAIL;
                end
            end
        end else if (!s_r.settled && bitTick) begin
            s_nxt.settled = 1'b1; // the bit on the air is finished
        end

        // serialiser, one bit per bit-rate tick
        if (bitTick && (s_r.ser == SER_SYNC || s_r.ser == SER_DATA)) begin
            s_nxt.txData = s_r.txSh[7];
            s_nxt.txSh = {s_r.txSh[6:0], 1'b0};
            s_nxt.txBit = s_r.txBit + 3'h1;
            if (s_r.txBit == 3'h7) begin
                if (s_r.ser == SER_SYNC && s_r.syncIdx != s_r.patCfg[2:0]) begin
                    s_nxt.syncIdx = s_r.syncIdx + 3'h1;
                    s_nxt.txSh = s_r.pat[3'h6 - s_r.syncIdx];
                end else if (s_r.count != 7'h0) begin
                    s_nxt.ser = SER_DATA;
                    s_nxt.txSh = s_r.mem[s_r.rdPtr];
                    pop = 1'b1;
                end else begin
                    s_nxt.ser = SER_TAIL;
                end
            end
        end else if (bitTick && s_r.ser == SER_TAIL) begin
            s_nxt.ser = SER_DONE;
            s_nxt.sent = 1'b1;
            s_nxt.txData = 1'b0;
        end

        // receiver: hunt for the pattern, then gather bytes
        if (s_r.mode == MODE_RX && rxStrobe) begin
            s_nxt.win = winN;
            if (s_r.rxLock || !s_r.patCfg[PAT_EN_BIT]) begin
                s_nxt.rxSh = {s_r.rxSh[6:0], rxBit};
                s_nxt.rxCnt = s_r.rxCnt + 3'h1;
                if (s_r.rxCnt == 3'h7) begin
                    push = 1'b1;
                    pushByte = {s_r.rxSh[6:0], rxBit};
                end
            end else if (hit) begin
                s_nxt.rxLock = 1'b1;
                s_nxt.match = 1'b1;
                matchSet = 1'b1;
                s_nxt.rxCnt = 3'h0;
            end
        end

        // buffer bookkeeping; a set of match wins over its clear, a clear of overflow wins over its set
        doPush = push && (s_r.count != FULL_COUNT) && !flush;
        doPop = pop && (s_r.count != 7'h0) && !flush;
        if (push && s_r.count == FULL_COUNT && !flush) begin
            s_nxt.overflow = 1'b1;
        end
        if (doPush) begin
            s_nxt.mem[s_r.wrPtr] = pushByte;
            s_nxt.wrPtr = s_r.wrPtr + 6'h1;
        end
        if (doPop) begin
            s_nxt.rdPtr = s_r.rdPtr + 6'h1;
        end
        cnt = s_r.count + {6'h0, doPush} - {6'h0, doPop};
        if (flush) begin
            s_nxt.rdPtr = 6'h0;
            s_nxt.wrPtr = 6'h0;
            cnt = 7'h0;
            s_nxt.level = 1'b0;
            s_nxt.levelHold = 1'b0;
        end else if (doPush || doPop) begin
            if (cnt == FULL_COUNT) begin
                s_nxt.levelHold = 1'b1;
            end else if (cnt == 7'h0) begin
                s_nxt.levelHold = 1'b0;
            end
            if (!s_nxt.levelHold) begin
                s_nxt.level = cnt > {1'b0, s_r.thresh};
            end
        end
        if ((flush || doPop) && cnt == 7'h0 && !matchSet) begin
            s_nxt.match = 1'b0;
        end
        s_nxt.count = cnt;
        s_nxt.brim = (cnt == FULL_COUNT);
        // vacant only moves outside a frame or as a frame opens
        if (!selected || nssFall) begin
            s_nxt.vacant = (cnt == 7'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.nssS <= 3'h7;
            s_r.vacant <= 1'b1;
            s_r.settled <= 1'b1;
            s_r.mode <= MODE_RST;
            s_r.thresh <= THRESH_RST;
            s_r.patCfg <= PATCFG_RST;
            s_r.pat <= PAT_RST;
            s_r.ser <= SER_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign lnk.miso = s_r.outSh[7];
    assign lnk.vacant = s_r.vacant;
    assign lnk.brim = s_r.brim;
    assign lnk.level = s_r.level;
    assign lnk.sent = s_r.sent;
    assign lnk.match = s_r.match;
    assign lnk.settled = s_r.settled;
    assign txData = s_r.txData;
    assign frameSent = s_r.sent;
    assign matchFlag = s_r.match;
    assign chipMode = s_r.mode;
endmodule // pkt_fifo_device

// File: inc/pkt_fifo_pkg.sv
// shared constants and types for the packet buffer and its host controller
package pkt_fifo_pkg;
    // buffer geometry
    localparam int DEPTH = 64;
    localparam logic [6:0] FULL_COUNT = 7'h40;
    // link register addresses seen by the host over the serial link
    localparam logic [6:0] ADDR_DATA = 7'h00;
    localparam logic [6:0] ADDR_MODE = 7'h01;
    localparam logic [6:0] ADDR_FLAGS = 7'h02;
    localparam logic [6:0] ADDR_THRESH = 7'h03;
    localparam logic [6:0] ADDR_PATCFG = 7'h04;
    localparam logic [6:0] ADDR_PATBYTE0 = 7'h05;
    localparam logic [6:0] PAT_BYTES = 7'h08;
    // chip modes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_STBY = 2'h1;
    localparam logic [1:0] MODE_TX = 2'h2;
    localparam logic [1:0] MODE_RX = 2'h3;
    // flag register bit positions; PAT_EN_BIT is a bit of the pattern config register
    localparam int FLG_VACANT = 0;
    localparam int FLG_BRIM = 1;
    localparam int FLG_LEVEL = 2;
    localparam int FLG_OVERFLOW = 3;
    localparam int FLG_SENT = 4;
    localparam int FLG_MATCH = 5;
    localparam int FLG_SETTLED = 6;
    localparam int PAT_EN_BIT = 7;
    // values after reset
    localparam logic [1:0] MODE_RST = 2'h1;
    localparam logic [5:0] THRESH_RST = 6'h0F;
    localparam logic [7:0] PATCFG_RST = 8'h83;
    localparam logic [63:0] PAT_RST = 64'hAAAA_AAAA_AAAA_AAAA;
    // serial frame: one command byte then one data byte
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // link clock made by the host
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCK_PERIOD_NS = 125;
    localparam logic [4:0] SCK_HALF = 5'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    // host Avalon offsets
    localparam logic [1:0] AV_CMD = 2'h0;
    localparam logic [1:0] AV_STATUS = 2'h1;
    // serialiser states
    typedef enum logic [4:0] {
        SER_IDLE = 5'b00001,
        SER_SYNC = 5'b00010,
        SER_DATA = 5'b00100,
        SER_TAIL = 5'b01000,
        SER_DONE = 5'b10000
    } ser_t;
    // host link states
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_XFER = 3'b010,
        H_GAP = 3'b100
    } hst_t;
endpackage

// File: inc/pkt_link_if.sv
// serial link and status pins between host controller and packet buffer
`timescale 1ns/10ps
interface pkt_link_if;
    logic nssN;
    logic sck;
    logic mosi;
    logic miso;
    logic vacant;
    logic brim;
    logic level;
    logic sent;
    logic match;
    logic settled;
    modport device (
        input nssN, sck, mosi,
        output miso, vacant, brim, level, sent, match, settled
    );
    modport host (
        output nssN, sck, mosi,
        input miso, vacant, brim, level, sent, match, settled
    );
endinterface

// File: rtl/pkt_fifo_host.sv
// host controller end: Avalon-MM command registers driving the serial link
`timescale 1ns/10ps
module pkt_fifo_host (
    input wire logic clock,
    input wire logic nrst,
    pkt_link_if.host lnk,
    input wire logic [1:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWritedata,
    output logic [31:0] avReaddata,
    output logic avWaitrequest
);
    import pkt_fifo_pkg::*;

    typedef struct packed {
        logic [1:0] misoS;
        logic [5:0] pin0;
        logic [5:0] pin1;
        hst_t st;
        logic [4:0] divCnt;
        logic [4:0] bitCnt;
        logic [15:0] sh;
        logic [7:0] rdData;
        logic sck;
        logic nssN;
        logic waitReq;
        logic [31:0] rdOut;
    } host_t;

    host_t s_r, s_nxt;
    logic halfTick;

    assign halfTick = (s_r.divCnt == SCK_HALF - 5'h1);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_nxt = s_r;
        // pins from the device pass two flip-flops before use
        s_nxt.misoS = {s_r.misoS[0], lnk.miso};
        s_nxt.pin0 = {lnk.settled, lnk.match, lnk.sent, lnk.level, lnk.brim, lnk.vacant};
        s_nxt.pin1 = s_r.pin0;
        s_nxt.divCnt = halfTick ? 5'h0 : s_r.divCnt + 5'h1;

        // bus slave: accept one cycle, drop waitrequest the next
        s_nxt.waitReq = 1'b1;
        if ((avRead || avWrite) && s_r.waitReq
            && !(avWrite && avAddress == AV_CMD && s_r.st != H_IDLE)) begin
            s_nxt.waitReq = 1'b0;
            s_nxt.rdOut = (avAddress == AV_STATUS) ? {10'h0, s_r.pin1, s_r.rdData, 7'h0,
                s_r.st != H_IDLE} : 32'h0;
        end
        if (avWrite && !s_r.waitReq && avAddress == AV_CMD) begin
            s_nxt.st = H_XFER;
            s_nxt.sh = avWritedata[15:0];
            s_nxt.nssN = 1'b0;
            s_nxt.sck = 1'b0;
            s_nxt.bitCnt = 5'h0;
            s_nxt.divCnt = 5'h0;
        end

        // link sequencer: sck idles low, device samples on the rise
        case (s_r.st)
            H_IDLE: ;
            H_XFER: begin
                if (halfTick) begin
                    s_nxt.sck = ~s_r.sck;
                    if (!s_r.sck) begin
                        s_nxt.bitCnt = s_r.bitCnt + 5'h1;
                        if (s_r.bitCnt > CMD_LAST_BIT) begin
                            s_nxt.rdData = {s_r.rdData[6:0], s_r.misoS[1]};
                        end
                    end else if (s_r.bitCnt == FRAME_BITS) begin
                        s_nxt.st = H_GAP;
                        s_nxt.nssN = 1'b1;
                    end else begin
                        s_nxt.sh = {s_r.sh[14:0], 1'b0};
                    end
                end
            end
            H_GAP: begin
                // nss stays high long enough for the device to see it
                if (halfTick) begin
                    s_nxt.st = H_IDLE;
                end
            end
            default: s_nxt.st = H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.st <= H_IDLE;
            s_r.nssN <= 1'b1;
            s_r.waitReq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.nssN = s_r.nssN;
    assign lnk.sck = s_r.sck;
    assign lnk.mosi = s_r.sh[15];
    assign avReaddata = s_r.rdOut;
    assign avWaitrequest = s_r.waitReq;
endmodule // pkt_fifo_host

// File: bench/pkt_fifo_properties.sv
// link-side assertions for the packet buffer and its host controller
`timescale 1ns/10ps
module pkt_fifo_properties
    import pkt_fifo_pkg::*;
#(
    parameter int BIT_DIV = 4000
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic nssN,
    input wire logic sck,
    input wire logic vacant,
    input wire logic brim,
    input wire logic level,
    input wire logic match,
    input wire logic settled
);
    logic sckQ;
    logic [7:0] hiCnt;
    logic [4:0] riseCnt;
    int lowCnt;
    ////////////////////////////////////////////////////////////////////////////////
    // run counters stand in for long repetitions
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sckQ <= 1'b0;
            hiCnt <= 8'h00;
            riseCnt <= 5'h00;
            lowCnt <= 0;
        end else begin
            sckQ <= sck;
            hiCnt <= sck ? hiCnt + 8'h01 : 8'h00;
            riseCnt <= nssN ? 5'h00 : riseCnt + 5'(sck & ~sckQ);
            lowCnt <= settled ? 0 : lowCnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // status pins
    vacant_brim_excl_a: assert property (!(vacant && brim))
        else $error("empty and full together");
    vacant_frame_hold_a: assert property ((!nssN) [*6] |=> $stable(vacant))
        else $error("empty flag moved inside a frame");
    level_full_freeze_a: assert property (brim && $past(brim) |-> $stable(level))
        else $error("level moved while full");
    brim_after_fill_a: assert property ($rose(brim) |-> !$past(vacant))
        else $error("full straight from empty");
    match_empty_clear_a: assert property ($rose(vacant) |-> ##[0:2] !match)
        else $error("match kept after emptying");
    settle_bound_a: assert property (lowCnt <= BIT_DIV + 2)
        else $error("settled came late");
    // link framing
    sck_idle_low_a: assert property (nssN |-> !sck)
        else $error("link clock moved outside a frame");
    sck_half_a: assert property ($fell(sck) |-> hiCnt == 8'(SCK_HALF))
        else $error("link clock high phase wrong");
    frame_len_a: assert property ($rose(nssN) |-> riseCnt == FRAME_BITS)
        else $error("frame bit count wrong");
endmodule // pkt_fifo_properties

// File: bench/packet_fifo_sync_detect_test.sv
// self-checking bench joining host controller and packet buffer
`timescale 1ns/10ps
module packet_fifo_sync_detect_test;
    import pkt_fifo_pkg::*;
    localparam int DIV = 8;
    localparam int LIMIT = 3000;
    logic clock;
    logic nrst;
    logic rxBit;
    logic rxStrobe;
    logic txData;
    logic frameSent;
    logic matchFlag;
    logic [1:0] chipMode;
    logic [1:0] avAddress;
    logic avRead;
    logic avWrite;
    logic [31:0] avWritedata;
    logic [31:0] avReaddata;
    logic avWaitrequest;
    logic [31:0] w;
    logic [7:0] q;
    logic [23:0] txSeen;
    int waitN;
    int badCount;
    int checked;
    ////////////////////////////////////////////////////////////////////////////////
    // the two ends face each other; the checker watches the link between them
    pkt_link_if pkt_link_if_i ();
    wire vacant = pkt_link_if_i.vacant;
    wire brim = pkt_link_if_i.brim;
    wire level = pkt_link_if_i.level;
    pkt_fifo_device #(.BIT_DIV(DIV)) pkt_fifo_device_i (.clock(clock), .nrst(nrst),
        .lnk(pkt_link_if_i.device), .rxBit(rxBit), .rxStrobe(rxStrobe), .txData(txData),
        .frameSent(frameSent), .matchFlag(matchFlag), .chipMode(chipMode));
    pkt_fifo_host pkt_fifo_host_i (.clock(clock), .nrst(nrst), .lnk(pkt_link_if_i.host),
        .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
        .avReaddata(avReaddata), .avWaitrequest(avWaitrequest));
    pkt_fifo_properties #(.BIT_DIV(DIV)) pkt_fifo_properties_i (.clock(clock), .nrst(nrst),
        .nssN(pkt_link_if_i.nssN), .sck(pkt_link_if_i.sck), .vacant(pkt_link_if_i.vacant),
        .brim(pkt_link_if_i.brim), .level(pkt_link_if_i.level), .match(pkt_link_if_i.match),
        .settled(pkt_link_if_i.settled));
    ////////////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bounded-wait helpers
    task automatic results();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout(input int n);
        if (n >= LIMIT) begin
            badCount++;
            $display("mismatch at %0t: wait ran out", $time);
            results();
        end
    endtask
    // one Avalon transfer; released at the edge that sees waitrequest low
    task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        avAddress <= a;
        avWritedata <= d;
        avWrite <= wr;
        avRead <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avWaitrequest !== 1'b0 && n < LIMIT);
        rd = avReaddata;
        timeout(n);
        avWrite <= 1'b0;
        avRead <= 1'b0;
    endtask
    // one link frame via the host, then poll busy; read byte lands in q
    task automatic link(input logic wr, input logic [6:0] a, input logic [7:0] d);
        logic [31:0] s;
        int n;
        n = 0;
        av(1'b1, AV_CMD, {16'h0000, wr, a, d}, s);
        do begin
            av(1'b0, AV_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[0] !== 1'b0 && n < LIMIT);
        timeout(n);
        q = s[15:8];
    endtask
    // demodulated bits, MSB first, one strobe each
    task automatic rxSend(input logic [15:0] v);
        for (int b = 15; b >= 0; b--) begin
            @(posedge clock);
            rxBit <= v[b];
            rxStrobe <= 1'b1;
            @(posedge clock);
            rxStrobe <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        rxBit = 1'b0;
        rxStrobe = 1'b0;
        avAddress = 2'h0;
        avRead = 1'b0;
        avWrite = 1'b0;
        avWritedata = 32'h0000_0000;
        badCount = 0;
        checked = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        check(vacant, 1'b1);
        check(chipMode, MODE_RST);
        link(1'b0, ADDR_THRESH, 8'h00);
        check(q, 8'(THRESH_RST));
        link(1'b0, ADDR_PATCFG, 8'h00);
        check(q, PATCFG_RST);
        link(1'b0, ADDR_PATBYTE0, 8'h00);
        check(q, PAT_RST[63:56]);
        av(1'b0, 2'h3, 32'h0000_0000, w);
        check(w, 32'h0000_0000);
        $display("reset test done");
        // fill to the brim; threshold alone must not move the level flag
        for (int i = 0; i < DEPTH; i++) begin
            link(1'b1, ADDR_DATA, 8'(i + 1));
            check(level, 1'(i >= 15 && i != 20));
            check(brim, 1'(i == DEPTH - 1));
            check(vacant, 1'b0);
            if (i == 19) begin
                link(1'b1, ADDR_THRESH, 8'h3F);
                check(level, 1'b1);
            end
            if (i == 20) begin
                link(1'b1, ADDR_THRESH, 8'h0F);
            end
        end
        link(1'b1, ADDR_DATA, 8'hEE);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_OVERFLOW], 1'b1);
        link(1'b1, ADDR_THRESH, 8'h3F);
        for (int i = 0; i < DEPTH; i++) begin
            link(1'b0, ADDR_DATA, 8'h00);
            check(q, 8'(i + 1));
            check(vacant, 1'(i == DEPTH - 1));
            if (i == 0) begin
                check(level, 1'b1);
                check(brim, 1'b0);
            end
        end
        link(1'b1, ADDR_DATA, 8'h11);
        check(level, 1'b0);
        link(1'b1, ADDR_THRESH, 8'h01);
        link(1'b1, ADDR_DATA, 8'h22);
        check(level, 1'b1);
        link(1'b1, ADDR_FLAGS, 8'(1 << FLG_OVERFLOW));
        check(vacant, 1'b1);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_OVERFLOW], 1'b0);
        $display("fill test done");
        // mode transitions, receive and pattern recognition
        link(1'b1, ADDR_DATA, 8'h33);
        link(1'b1, ADDR_MODE, {6'h00, MODE_SLEEP});
        check(vacant, 1'b0);
        link(1'b1, ADDR_MODE, {6'h00, MODE_STBY});
        check(vacant, 1'b0);
        link(1'b1, ADDR_PATCFG, 8'h01);
        link(1'b1, ADDR_PATBYTE0, 8'h12);
        link(1'b1, ADDR_PATBYTE0 + 7'h01, 8'h34);
        link(1'b1, ADDR_MODE, {6'h00, MODE_RX});
        check(vacant, 1'b1);
        rxSend(16'h1234);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_MATCH], 1'b0);
        link(1'b1, ADDR_MODE, {6'h00, MODE_STBY});
        link(1'b0, ADDR_DATA, 8'h00);
        check(q, 8'h12);
        link(1'b0, ADDR_DATA, 8'h00);
        check(q, 8'h34);
        link(1'b1, ADDR_PATCFG, 8'h81);
        link(1'b1, ADDR_MODE, {6'h00, MODE_RX});
        rxSend(16'h3412);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_MATCH], 1'b0);
        rxSend(16'h1234);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_MATCH], 1'b1);
        check(matchFlag, 1'b1);
        rxSend(16'hC35A);
        link(1'b0, ADDR_DATA, 8'h00);
        check(q, 8'hC3);
        link(1'b0, ADDR_DATA, 8'h00);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_MATCH], 1'b0);
        rxSend(16'h1234);
        link(1'b1, ADDR_MODE, {6'h00, MODE_STBY});
        check(matchFlag, 1'b0);
        $display("receive test done");
        // rx to tx clears; a preloaded frame is serialised
        link(1'b1, ADDR_PATBYTE0, 8'h92);
        link(1'b1, ADDR_MODE, {6'h00, MODE_RX});
        rxSend(16'h9234);
        rxSend(16'h7E7E);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(vacant, 1'b0);
        link(1'b1, ADDR_MODE, {6'h00, MODE_TX});
        check(vacant, 1'b1);
        link(1'b1, ADDR_MODE, {6'h00, MODE_STBY});
        link(1'b1, ADDR_DATA, 8'hA5);
        fork
            link(1'b1, ADDR_MODE, {6'h00, MODE_TX});
            begin
                waitN = 0;
                while (txData !== 1'b1 && waitN < LIMIT) begin
                    @(negedge clock);
                    waitN++;
                end
                timeout(waitN);
                repeat (3) @(negedge clock);
                for (int b = 23; b >= 0; b--) begin
                    txSeen[b] = txData;
                    repeat (DIV) @(negedge clock);
                end
            end
        join
        check(txSeen, 24'h9234A5);
        check(frameSent, 1'b1);
        link(1'b1, ADDR_MODE, {6'h00, MODE_SLEEP});
        check(vacant, 1'b1);
        link(1'b0, ADDR_FLAGS, 8'h00);
        check(q[FLG_SETTLED], 1'b1);
        check(chipMode, MODE_SLEEP);
        $display("transmit test done");
        results();
    end
endmodule // packet_fifo_sync_detect_test
